/* File: wdog_sm.sv */
// watchdogs and slave state machine of a fieldbus slave controller
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module wdog_sm #(
    parameter int OUT_W = 8 // physical output / input width
) (
    input  wire logic             CLK,
    input  wire logic             SYS_RST,
    input  wire logic [7:0]       ADDR,      // register byte address
    input  wire logic [31:0]      WDATA,
    input  wire logic             WR,        // one-cycle write strobe
    input  wire logic             RD,        // one-cycle read strobe
    output logic [31:0]           RDATA,     // valid the cycle after RD
    input  wire logic             PD_DONE,   // process exchange completed ok
    input  wire logic             LI_XFER,   // local interface transfer seen
    input  wire logic             MBX_REQ,   // mailbox frame offered
    input  wire logic             MBX_FILE,  // offered mailbox is file transfer
    input  wire logic [OUT_W-1:0] IN_PINS,   // physical inputs, asynchronous
    output logic [OUT_W-1:0]      OUT_PINS,  // physical outputs
    output logic                  MBX_OK,    // mailbox frame accepted
    output logic                  PD_OK,     // process data accepted
    output logic [2:0]            STATE      // operating state code
);
    // all state of the module
    typedef struct packed {
        wdog_pkg::slave_state_t state; // operating state
        logic [15:0]      mult;      // shared tick multiplier
        logic [15:0]      ft_count;  // frame-traffic reload count
        logic [15:0]      li_count;  // local-interface reload count
        logic             ft_en;     // frame-traffic watchdog enable
        logic             li_en;     // local-interface watchdog enable
        logic [2:0]       cfg;       // channel and clock setup checks
        logic             reject;    // last state request refused
        logic [OUT_W-1:0] out_data;  // output image from the master
        logic [OUT_W-1:0] in_snap;   // input image for the master
        logic [OUT_W-1:0] in_s1;     // synchroniser first stage
        logic [OUT_W-1:0] in_s2;     // synchroniser second stage
        logic [1:0]       base_cnt;  // 100 MHz to 25 MHz divider
        logic [16:0]      tick_cnt;  // base periods within a tick
        logic             tick;
        logic [15:0]      ft_rem;
        logic [15:0]      li_rem;
        logic             ft_exp;
        logic             li_exp;
        logic [31:0]      rdata;
        logic [OUT_W-1:0] out_pins;
        logic             mbx_ok;
        logic             pd_ok;
    } regs_t;

    // one struct holds every flop, so reset and the register copy stay in step;
    // the trade is that a single reset clears the configuration with the counters
    regs_t cur_r; // registered state
    regs_t nxt;   // next state

    // decode a requested state code into the enum, invalid maps to init
    function automatic wdog_pkg::slave_state_t code_to_state(input logic [2:0] c);
        case (c)
            3'h1:    code_to_state = wdog_pkg::ST_PREP;
            3'h2:    code_to_state = wdog_pkg::ST_GUARD;
            3'h3:    code_to_state = wdog_pkg::ST_RUN;
            3'h4:    code_to_state = wdog_pkg::ST_FWUPD;
            default: code_to_state = wdog_pkg::ST_INIT;
        endcase
    endfunction : code_to_state

    // next-state logic: everything the block will hold after the next edge;
    // bus strobes, traffic pulses and the tick are all seen one cycle late,
    // which keeps every output a plain flop at the cost of one cycle of delay
    always_comb begin
        wdog_pkg::slave_state_t req;
        logic                   ok;
        logic [16:0]            tick_len;
        req      = code_to_state(WDATA[wdog_pkg::CTRL_REQ_LSB +: 3]);
        ok       = 1'b0;
        tick_len = 17'({1'b0, cur_r.mult}) + 17'(wdog_pkg::TICK_EXTRA);
        nxt      = cur_r;
        nxt.rdata = 32'h0000_0000;
        // input synchroniser; only the second stage is read by logic
        nxt.in_s1 = IN_PINS;
        nxt.in_s2 = cur_r.in_s1;

        // base 25 MHz period and watchdog tick of mult+2 periods;
        // the tick is a one-cycle pulse shared by both watchdogs, so their
        // timeouts stay in a fixed ratio whatever the multiplier holds
        nxt.tick = 1'b0;
        if (cur_r.base_cnt == 2'(wdog_pkg::BASE_CYCLES - 1)) begin
            nxt.base_cnt = 2'h0;
            if (cur_r.tick_cnt >= tick_len - 17'h00001) begin
                nxt.tick_cnt = 17'h00000;
                nxt.tick     = 1'b1;
            end else begin
                nxt.tick_cnt = cur_r.tick_cnt + 17'h00001;
            end
        end else begin
            nxt.base_cnt = cur_r.base_cnt + 2'h1;
        end

        // frame-traffic watchdog: reload only on a good exchange;
        // an exchange that the state gating refused must not count, otherwise
        // a master talking to a slave in preparation would keep it alive
        if (PD_DONE && cur_r.pd_ok) begin
            nxt.ft_rem = cur_r.ft_count;
            nxt.ft_exp = 1'b0;
        end else if (cur_r.tick && cur_r.ft_rem != 16'h0000) begin
            nxt.ft_rem = cur_r.ft_rem - 16'h0001;
        end
        if (cur_r.ft_en && cur_r.ft_count != 16'h0000 && cur_r.ft_rem == 16'h0000
            && !(PD_DONE && cur_r.pd_ok)) begin
            nxt.ft_exp = 1'b1;
        end
        if (!cur_r.ft_en || cur_r.ft_count == 16'h0000) begin
            nxt.ft_exp = 1'b0;
        end

        // local-interface watchdog: any local transfer reloads it; it only
        // reports expiry and leaves the outputs alone
        if (LI_XFER) begin
            nxt.li_rem = cur_r.li_count;
            nxt.li_exp = 1'b0;
        end else if (cur_r.tick && cur_r.li_rem != 16'h0000) begin
            nxt.li_rem = cur_r.li_rem - 16'h0001;
        end
        if (cur_r.li_en && cur_r.li_count != 16'h0000 && cur_r.li_rem == 16'h0000
            && !LI_XFER) begin
            nxt.li_exp = 1'b1;
        end
        if (!cur_r.li_en) begin
            nxt.li_exp = 1'b0;
        end

        // register writes
        if (WR) begin
            case (ADDR)
                wdog_pkg::REG_CTRL: begin
                    nxt.ft_en  = WDATA[wdog_pkg::CTRL_FT_EN];
                    nxt.li_en  = WDATA[wdog_pkg::CTRL_LI_EN];
                    nxt.reject = 1'b0;
                    // state transition checks
                    case (req)
                        wdog_pkg::ST_INIT:  ok = 1'b1;
                        wdog_pkg::ST_PREP:  ok = (cur_r.state == wdog_pkg::ST_INIT ||
                                                  cur_r.state == wdog_pkg::ST_PREP ||
                                                  cur_r.state == wdog_pkg::ST_GUARD ||
                                                  cur_r.state == wdog_pkg::ST_RUN) &&
                                                 cur_r.cfg[wdog_pkg::CFG_MBX_OK];
                        wdog_pkg::ST_GUARD: ok = (cur_r.state == wdog_pkg::ST_PREP ||
                                                  cur_r.state == wdog_pkg::ST_GUARD ||
                                                  cur_r.state == wdog_pkg::ST_RUN) &&
                                                 cur_r.cfg[wdog_pkg::CFG_PD_OK] &&
                                                 cur_r.cfg[wdog_pkg::CFG_CLK_OK];
                        wdog_pkg::ST_RUN:   ok = (cur_r.state == wdog_pkg::ST_GUARD ||
                                                  cur_r.state == wdog_pkg::ST_RUN);
                        wdog_pkg::ST_FWUPD: ok = (cur_r.state == wdog_pkg::ST_INIT ||
                                                  cur_r.state == wdog_pkg::ST_FWUPD);
                        default:            ok = 1'b0;
                    endcase
                    if (ok) begin
                        nxt.state = req;
                        // snapshot inputs before acknowledging guarded run
                        if (req == wdog_pkg::ST_GUARD && cur_r.state == wdog_pkg::ST_PREP) begin
                            nxt.in_snap = cur_r.in_s2;
                        end
                    end else begin
                        nxt.reject = 1'b1;
                    end
                end
                // settings are written on any write strobe; a multiplier value of zero is ignored
                wdog_pkg::REG_MULT: begin
                    if (WDATA[15:0] != 16'h0000) begin
                        nxt.mult = WDATA[15:0];
                    end
                end
                wdog_pkg::REG_FT_COUNT: begin
                    nxt.ft_count = WDATA[15:0];
                    nxt.ft_rem   = WDATA[15:0];
                end
                wdog_pkg::REG_LI_COUNT: begin
                    nxt.li_count = WDATA[15:0];
                    nxt.li_rem   = WDATA[15:0];
                end
                wdog_pkg::REG_CFG:      nxt.cfg = WDATA[2:0];
                wdog_pkg::REG_OUT_DATA: nxt.out_data = WDATA[OUT_W-1:0];
                default: begin
                    // unmapped or read-only address: write ignored
                end
            endcase
        end

        // guarded run keeps refreshing the input image cyclically
        if (cur_r.state == wdog_pkg::ST_GUARD || cur_r.state == wdog_pkg::ST_RUN) begin
            nxt.in_snap = cur_r.in_s2;
        end

        // traffic gating by state
        case (cur_r.state)
            wdog_pkg::ST_INIT: begin
                nxt.mbx_ok = 1'b0;
                nxt.pd_ok  = 1'b0;
            end
            wdog_pkg::ST_PREP: begin
                nxt.mbx_ok = MBX_REQ;
                nxt.pd_ok  = 1'b0;
            end
            wdog_pkg::ST_GUARD, wdog_pkg::ST_RUN: begin
                nxt.mbx_ok = MBX_REQ;
                nxt.pd_ok  = 1'b1;
            end
            wdog_pkg::ST_FWUPD: begin
                nxt.mbx_ok = MBX_REQ && MBX_FILE;
                nxt.pd_ok  = 1'b0;
            end
            default: begin
                nxt.mbx_ok = 1'b0;
                nxt.pd_ok  = 1'b0;
            end
        endcase

        // outputs: only run drives data, and never while the frame watchdog is expired
        if (cur_r.state == wdog_pkg::ST_RUN && !cur_r.ft_exp) begin
            nxt.out_pins = cur_r.out_data;
        end else begin
            nxt.out_pins = '0;
        end

        // register reads, data valid the next cycle; rdata falls back to
        // zero in every other cycle, so a stale word is never seen twice
        if (RD) begin
            case (ADDR)
                wdog_pkg::REG_CTRL:     nxt.rdata = {26'h0, cur_r.ft_en, cur_r.li_en,
                                                     1'b0, cur_r.state};
                wdog_pkg::REG_STATUS:   nxt.rdata = {25'h0, cur_r.reject, cur_r.li_exp,
                                                     cur_r.ft_exp, 1'b0, cur_r.state};
                wdog_pkg::REG_MULT:     nxt.rdata = {16'h0, cur_r.mult};
                wdog_pkg::REG_FT_COUNT: nxt.rdata = {16'h0, cur_r.ft_count};
                wdog_pkg::REG_LI_COUNT: nxt.rdata = {16'h0, cur_r.li_count};
                wdog_pkg::REG_CFG:      nxt.rdata = {29'h0, cur_r.cfg};
                wdog_pkg::REG_OUT_DATA: nxt.rdata = 32'(cur_r.out_data);
                wdog_pkg::REG_IN_SNAP:  nxt.rdata = 32'(cur_r.in_snap);
                default:                nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // state register; reset takes constants only
    // reset is synchronous, so a glitch between edges cannot corrupt it
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cur_r          <= '0;
            cur_r.state    <= wdog_pkg::ST_INIT;
            cur_r.mult     <= wdog_pkg::MULT_RESET;
            cur_r.ft_count <= wdog_pkg::FT_COUNT_RESET;
            cur_r.li_count <= wdog_pkg::LI_COUNT_RESET;
            cur_r.ft_rem   <= wdog_pkg::FT_COUNT_RESET;
            cur_r.li_rem   <= wdog_pkg::LI_COUNT_RESET;
        end else begin
            cur_r <= nxt;
        end
    end

    // every output is a field of the registered struct, no logic after the flop
    assign RDATA    = cur_r.rdata;
    assign OUT_PINS = cur_r.out_pins;
    assign MBX_OK   = cur_r.mbx_ok;
    assign PD_OK    = cur_r.pd_ok;
    assign STATE    = cur_r.state;

    // checks below watch registered outputs, which are one cycle behind the
    // state that produced them; $past lines the two up
    // expiry never moves the state
    property p_exp_keeps_state;
        @(posedge CLK) disable iff (SYS_RST)
        ($rose(cur_r.ft_exp) && !$past(WR)) |-> cur_r.state == $past(cur_r.state);
    endproperty
    a_exp_keeps_state: assert property (p_exp_keeps_state) else $error("state moved on expiry");

    // expired frame watchdog forces outputs low next cycle
    property p_exp_outputs_low;
        @(posedge CLK) disable iff (SYS_RST) cur_r.ft_exp |=> OUT_PINS == '0;
    endproperty
    a_exp_outputs_low: assert property (p_exp_outputs_low) else $error("outputs not forced low");

    // zero count never expires
    property p_zero_disables;
        @(posedge CLK) disable iff (SYS_RST) cur_r.ft_count == 16'h0000 |=> !cur_r.ft_exp;
    endproperty
    a_zero_disables: assert property (p_zero_disables) else $error("disabled watchdog expired");

    // good exchange reloads the full count
    property p_reload;
        @(posedge CLK) disable iff (SYS_RST)
        (PD_DONE && cur_r.pd_ok && !WR) |=> cur_r.ft_rem == $past(cur_r.ft_count);
    endproperty
    a_reload: assert property (p_reload) else $error("frame watchdog not reloaded");

    // local transfer reloads the full local count
    property p_li_reload;
        @(posedge CLK) disable iff (SYS_RST)
        (LI_XFER && !WR) |=> cur_r.li_rem == $past(cur_r.li_count);
    endproperty
    a_li_reload: assert property (p_li_reload) else $error("li not reloaded");

    // no traffic in initialisation
    property p_init_refuse;
        @(posedge CLK) disable iff (SYS_RST)
        ($past(cur_r.state) == wdog_pkg::ST_INIT) |-> !MBX_OK && !PD_OK;
    endproperty
    a_init_refuse: assert property (p_init_refuse) else $error("traffic in init");

    // firmware update only reached from initialisation
    property p_fw_entry;
        @(posedge CLK) disable iff (SYS_RST)
        (cur_r.state == wdog_pkg::ST_FWUPD && $past(cur_r.state) != wdog_pkg::ST_FWUPD)
        |-> $past(cur_r.state) == wdog_pkg::ST_INIT;
    endproperty
    a_fw_entry: assert property (p_fw_entry) else $error("bad firmware update entry");

    // outputs stay low outside run
    property p_safe_outputs;
        @(posedge CLK) disable iff (SYS_RST)
        $past(cur_r.state) != wdog_pkg::ST_RUN |-> OUT_PINS == '0;
    endproperty
    a_safe_outputs: assert property (p_safe_outputs) else $error("outputs active outside run");

    // preparation never lets process data through
    property p_prep_no_pd;
        @(posedge CLK) disable iff (SYS_RST)
        $past(cur_r.state) == wdog_pkg::ST_PREP |-> !PD_OK;
    endproperty
    a_prep_no_pd: assert property (p_prep_no_pd) else $error("pd in preparation");

    // firmware update never lets process data through
    property p_fw_no_pd;
        @(posedge CLK) disable iff (SYS_RST)
        $past(cur_r.state) == wdog_pkg::ST_FWUPD |-> !PD_OK;
    endproperty
    a_fw_no_pd: assert property (p_fw_no_pd) else $error("pd in firmware update");

    // ticks spaced by the multiplier plus two base periods
    property p_tick_space;
        @(posedge CLK) disable iff (SYS_RST)
        (cur_r.tick && cur_r.mult == 16'h0001 && $stable(cur_r.mult)) |=> !cur_r.tick [*8] ##[1:8] cur_r.tick;
    endproperty
    a_tick_space: assert property (p_tick_space) else $error("tick spacing wrong");

    // a multiplier of zero is never taken
    property p_mult_nonzero;
        @(posedge CLK) disable iff (SYS_RST) cur_r.mult != 16'h0000;
    endproperty
    a_mult_nonzero: assert property (p_mult_nonzero) else $error("multiplier zero");

    // main scenarios worth seeing at least once
    c_fw: cover property (@(posedge CLK) cur_r.state == wdog_pkg::ST_FWUPD);
    c_reject: cover property (@(posedge CLK) cur_r.reject);
    c_run: cover property (@(posedge CLK) cur_r.state == wdog_pkg::ST_RUN);
    c_exp: cover property (@(posedge CLK) cur_r.ft_exp && cur_r.state == wdog_pkg::ST_RUN);
    c_li: cover property (@(posedge CLK) cur_r.li_exp);
endmodule : wdog_sm
`default_nettype wire

/* File: wdog_pkg.sv */
// package: constants for the watchdog and slave state machine block
package wdog_pkg;
    // register byte addresses, one 32-bit word apart
    localparam logic [7:0]  REG_CTRL       = 8'h00; // state request, watchdog enables
    localparam logic [7:0]  REG_STATUS     = 8'h04; // state, expiry flags, request rejected
    localparam logic [7:0]  REG_MULT       = 8'h08; // shared tick multiplier
    localparam logic [7:0]  REG_FT_COUNT   = 8'h0C; // frame-traffic watchdog count
    localparam logic [7:0]  REG_LI_COUNT   = 8'h10; // local-interface watchdog count
    localparam logic [7:0]  REG_CFG        = 8'h14; // channel configuration checks
    localparam logic [7:0]  REG_OUT_DATA   = 8'h18; // output data from the master
    localparam logic [7:0]  REG_IN_SNAP    = 8'h1C; // input snapshot memory
    // field positions
    localparam int CTRL_REQ_LSB   = 0;  // requested state, 3 bits
    localparam int CTRL_LI_EN     = 4;  // local-interface watchdog enable
    localparam int CTRL_FT_EN     = 5;  // frame-traffic watchdog enable
    localparam int CFG_MBX_OK     = 0;  // channels 0 and 1 set for mailbox
    localparam int CFG_PD_OK      = 1;  // channels from 2, mapping units ok
    localparam int CFG_CLK_OK     = 2;  // clock settings ok
    localparam int STAT_FT_EXP    = 4;
    localparam int STAT_LI_EXP    = 5;
    localparam int STAT_REJECT    = 6;
    // reset values
    localparam logic [15:0] MULT_RESET     = 16'h09C2; // 2498
    localparam logic [15:0] FT_COUNT_RESET = 16'h03E8; // 1000
    localparam logic [15:0] LI_COUNT_RESET = 16'h03E8; // 1000
    // timing: 25 MHz base period inside a 100 MHz clock
    localparam int CLK_NS       = 10;
    localparam int BASE_NS      = 40;
    localparam int BASE_CYCLES  = BASE_NS / CLK_NS;
    localparam int TICK_EXTRA   = 2; // base periods added to the multiplier
    // slave state machine states
    typedef enum logic [2:0] {
        ST_INIT, ST_PREP, ST_GUARD, ST_RUN, ST_FWUPD
    } slave_state_t;
endpackage : wdog_pkg

/* File: master_model.sv */
// partner model: fieldbus master issuing cyclic process-data exchanges
`timescale 1ns/10ps
`default_nettype none
module master_model (
    input  wire logic CLK,
    input  wire logic SYS_RST,
    input  wire logic run,      // master keeps cyclic traffic going
    output logic      PD_DONE   // one-cycle exchange-complete pulse
);
    logic [1:0] cyc_r; // one exchange every four clocks
    // dropping run models a broken line: the pulses simply stop
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cyc_r   <= 2'h0;
            PD_DONE <= 1'b0;
        end else begin
            cyc_r   <= cyc_r + 2'h1;
            PD_DONE <= run && (cyc_r == 2'h3);
        end
    end
endmodule : master_model
`default_nettype wire

/* File: tb_top.sv */
// testbench: register tests of the watchdogs and slave state machine
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        CLK, SYS_RST, WR, RD, LI_XFER, MBX_REQ, MBX_FILE, run;
    logic [7:0]  ADDR, IN_PINS;
    logic [31:0] WDATA, d;
    wire  [31:0] RDATA;
    wire  [7:0]  OUT_PINS;
    wire         PD_DONE, MBX_OK, PD_OK;
    wire  [2:0]  STATE;
    logic [1:0]  en;       // frame and local watchdog enables
    int          fails, compares, i;

    wdog_sm #(.OUT_W(8)) u_wdog_sm (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PD_DONE(PD_DONE),
        .LI_XFER(LI_XFER), .MBX_REQ(MBX_REQ), .MBX_FILE(MBX_FILE), .IN_PINS(IN_PINS),
        .OUT_PINS(OUT_PINS), .MBX_OK(MBX_OK), .PD_OK(PD_OK), .STATE(STATE));
    master_model u_master_model (.CLK(CLK), .SYS_RST(SYS_RST), .run(run),
        .PD_DONE(PD_DONE));

    // 100 MHz clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // compare and count
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // verdict and end of run
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK);
        ADDR <= a; WDATA <= v; WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr

    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge CLK);
        ADDR <= a; RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 v = RDATA;
    endtask : rd

    // state request keeps the current enable bits
    task automatic req(input logic [2:0] st);
        wr(wdog_pkg::REG_CTRL, {26'h0, en, 1'b0, st});
    endtask : req

    task automatic chk_st(input logic [2:0] exp);
        @(posedge CLK);
        #1 chk("state", {29'h0, STATE}, {29'h0, exp});
    endtask : chk_st

    // offer a mailbox frame for two cycles and look at the answer after the second edge
    task automatic mbx(input logic file, input logic exp);
        @(posedge CLK);
        MBX_REQ <= 1'b1; MBX_FILE <= file;
        repeat (2) @(posedge CLK);
        MBX_REQ <= 1'b0;
        #1 chk("mbx_ok", {31'h0, MBX_OK}, {31'h0, exp});
    endtask : mbx

    // hang guard
    initial begin
        #500000;
        fails++;
        results();
    end

    initial begin
        SYS_RST = 1'b1; WR = 1'b0; RD = 1'b0; LI_XFER = 1'b0; MBX_REQ = 1'b0;
        MBX_FILE = 1'b0; run = 1'b0; ADDR = 8'h00; WDATA = 32'h0; IN_PINS = 8'hA5;
        en = 2'h0; fails = 0; compares = 0;
        repeat (12) @(posedge CLK);
        SYS_RST <= 1'b0;
        // reset values and power-on state
        rd(wdog_pkg::REG_MULT, d);     chk("mult", d, 32'h000009C2);
        rd(wdog_pkg::REG_FT_COUNT, d); chk("ft_count", d, 32'h000003E8);
        rd(wdog_pkg::REG_LI_COUNT, d); chk("li_count", d, 32'h000003E8);
        rd(8'h40, d);                  chk("unmapped", d, 32'h0);
        chk_st(wdog_pkg::ST_INIT);
        // initialisation refuses all traffic
        mbx(1'b0, 1'b0);
        chk("pd_ok_init", {31'h0, PD_OK}, 32'h0);
        // preparation refused until mailbox channels are set up
        req(wdog_pkg::ST_PREP);
        chk_st(wdog_pkg::ST_INIT);
        rd(wdog_pkg::REG_STATUS, d);   chk("reject", {31'h0, d[6]}, 32'h1);
        wr(wdog_pkg::REG_CFG, 32'h1);
        req(wdog_pkg::ST_PREP);
        chk_st(wdog_pkg::ST_PREP);
        mbx(1'b0, 1'b1);
        chk("pd_ok_prep", {31'h0, PD_OK}, 32'h0);
        // firmware update only from initialisation
        req(wdog_pkg::ST_FWUPD);
        chk_st(wdog_pkg::ST_PREP);
        req(wdog_pkg::ST_INIT);
        req(wdog_pkg::ST_FWUPD);
        chk_st(wdog_pkg::ST_FWUPD);
        mbx(1'b1, 1'b1);
        mbx(1'b0, 1'b0);
        chk("pd_ok_fw", {31'h0, PD_OK}, 32'h0);
        // guarded run: outputs held safe, inputs captured
        req(wdog_pkg::ST_INIT);
        req(wdog_pkg::ST_PREP);
        wr(wdog_pkg::REG_CFG, 32'h7);
        wr(wdog_pkg::REG_OUT_DATA, 32'h5A);
        req(wdog_pkg::ST_GUARD);
        chk_st(wdog_pkg::ST_GUARD);
        rd(wdog_pkg::REG_IN_SNAP, d);  chk("snapshot", d, 32'hA5);
        @(posedge CLK);
        IN_PINS <= 8'h3C;
        repeat (6) @(posedge CLK);
        rd(wdog_pkg::REG_IN_SNAP, d);  chk("snap_cyc", d, 32'h3C);
        chk("out_guard", {24'h0, OUT_PINS}, 32'h0);
        chk("pd_ok_guard", {31'h0, PD_OK}, 32'h1);
        // run applies master data
        req(wdog_pkg::ST_RUN);
        repeat (3) @(posedge CLK);
        #1 chk("out_run", {24'h0, OUT_PINS}, 32'h5A);
        // short tick: (1 + 2) * 4 = 12 clocks, frame count of 3 ticks
        wr(wdog_pkg::REG_MULT, 32'h1);
        wr(wdog_pkg::REG_MULT, 32'h0);
        rd(wdog_pkg::REG_MULT, d);     chk("mult_zero", d, 32'h1);
        wr(wdog_pkg::REG_FT_COUNT, 32'h3);
        run <= 1'b1;
        en = 2'h2;
        req(wdog_pkg::ST_RUN);
        repeat (60) @(posedge CLK);
        #1 chk("out_fed", {24'h0, OUT_PINS}, 32'h5A);
        // line lost; local traffic must not feed the frame watchdog
        @(posedge CLK);
        run <= 1'b0; LI_XFER <= 1'b1;
        repeat (20) @(posedge CLK);
        #1 chk("out_early", {24'h0, OUT_PINS}, 32'h5A);
        for (i = 0; i < 40 && OUT_PINS !== 8'h00; i++) @(posedge CLK);
        #1 chk("out_expired", {24'h0, OUT_PINS}, 32'h0);
        chk_st(wdog_pkg::ST_RUN);
        rd(wdog_pkg::REG_STATUS, d);   chk("ft_exp", {31'h0, d[4]}, 32'h1);
        // traffic returns and reloads the frame watchdog
        run <= 1'b1;
        repeat (10) @(posedge CLK);
        #1 chk("out_back", {24'h0, OUT_PINS}, 32'h5A);
        // count zero switches the frame watchdog off
        wr(wdog_pkg::REG_FT_COUNT, 32'h0);
        run <= 1'b0;
        repeat (80) @(posedge CLK);
        #1 chk("out_off", {24'h0, OUT_PINS}, 32'h5A);
        // local watchdog with its own count on the shared tick
        @(posedge CLK);
        LI_XFER <= 1'b0;
        wr(wdog_pkg::REG_LI_COUNT, 32'h3);
        en = 2'h3;
        req(wdog_pkg::ST_RUN);
        repeat (20) @(posedge CLK);
        rd(wdog_pkg::REG_STATUS, d);   chk("li_early", {31'h0, d[5]}, 32'h0);
        repeat (25) @(posedge CLK);
        rd(wdog_pkg::REG_STATUS, d);   chk("li_exp", {31'h0, d[5]}, 32'h1);
        @(posedge CLK);
        LI_XFER <= 1'b1;
        @(posedge CLK);
        LI_XFER <= 1'b0;
        rd(wdog_pkg::REG_STATUS, d);   chk("li_clr", {31'h0, d[5]}, 32'h0);
        results();
    end
endmodule : tb_top
`default_nettype wire
